// file: verilog/default_start_watchdog.sv
`timescale 1ns/1ps
module default_start_watchdog
   import wdt_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [31:0] bus_addr_i,
   input wire logic bus_wr_i,
   input wire logic bus_rd_i,
   input wire logic bus_bit_op_i,
   input wire logic [7:0] bus_wdata_i,
   output logic [7:0] bus_rdata_o,
   input wire logic osc_clk_i,
   input wire logic lock_option_bit_i,
   input wire logic osc_stab_i,
   output logic overflow_reset_request_o,
   output logic overflow_nmi_request_o,
   output logic cpu_clk_to_osc_o
);

   //===========================================================
   // helpers
   //===========================================================
   // terminal count 2^exp - 1 for an exponent 12..23
   // one spare bit keeps 2^23 representable before the subtraction
   function automatic logic [CNT_W-1:0] term_count(input int exp_val);
      logic [CNT_W:0] full;
      full = '0;
      full[exp_val] = 1'b1;
      full = full - 1'b1;
      return full[CNT_W-1:0];
   endfunction

   //===========================================================
   // synchronisers for pins
   //===========================================================
   logic osc_s1_reg, osc_s2_reg, osc_s3_reg;
   logic lock_s1_reg, lock_s2_reg;
   logic stab_s1_reg, stab_s2_reg;

   // two flops per pin, third flop only for the oscillator edge
   always_ff @(posedge ref_clk_i) begin
      osc_s1_reg <= osc_clk_i;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      lock_s1_reg <= lock_option_bit_i;
      lock_s2_reg <= lock_s1_reg;
      stab_s1_reg <= osc_stab_i;
      stab_s2_reg <= stab_s1_reg;
   end

   //===========================================================
   // effective configuration
   //===========================================================
   logic [7:0] mode_reg, mode_next;
   logic written_reg, written_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rst_req_reg, rst_req_next;
   logic nmi_req_reg, nmi_req_next;
   logic osc_sw_reg, osc_sw_next;
   logic eff_run, eff_osc, eff_rst, eff_nmi;
   logic [2:0] eff_sel;
   logic tick, ovf_count, force_ovf, ovf;
   logic mode_wr, key_wr, key_good;
   logic [CNT_W-1:0] limit;

   // decode mode, select and lock option into what the counter uses
   always_comb begin
      eff_sel = mode_reg[2:0];
      if (lock_s2_reg) begin
         eff_run = 1'b1;
         eff_osc = 1'b1;
         eff_rst = 1'b1;
         eff_nmi = 1'b0;
      end else begin
         eff_run = (mode_reg[SEL_MSB] == 1'b0) && (mode_reg[6:5] != 2'b00);
         eff_osc = ~mode_reg[3];
         eff_rst = mode_reg[MODE_HI_POS];
         eff_nmi = ~mode_reg[MODE_HI_POS] & mode_reg[MODE_LO_POS];
      end
      limit = term_count((eff_osc ? OSC_EXP_BASE : MAIN_EXP_BASE) + int'(eff_sel));
      tick = eff_run && (eff_osc ? (osc_s2_reg & ~osc_s3_reg) : 1'b1);
      ovf_count = tick && (cnt_reg == limit);
   end

   // bus decode of the two registers
   always_comb begin
      mode_wr = bus_wr_i && (bus_addr_i == MODE_ADDR) && !bus_bit_op_i;
      key_wr = bus_wr_i && (bus_addr_i == KEY_ADDR);
      key_good = key_wr && !bus_bit_op_i && (bus_wdata_i == KEY_SERVICE);
      force_ovf = (mode_wr && written_reg)
         || (key_wr && !key_good);
      ovf = ovf_count || force_ovf;
   end

   //===========================================================
   // registers, counter and requests
   //===========================================================
   // next state of mode register, counter, read data and requests
   always_comb begin
      mode_next = mode_reg;
      written_next = written_reg;
      cnt_next = cnt_reg;
      rdata_next = rdata_reg;
      if (mode_wr && !written_reg) begin
         mode_next = {1'b0, bus_wdata_i[6:0]};
         written_next = 1'b1;
      end
      if (ovf || key_good || (mode_wr && !written_reg)) begin
         cnt_next = '0;
      end else if (tick) begin
         cnt_next = cnt_reg + 1'b1;
      end
      if (bus_rd_i && bus_addr_i == MODE_ADDR) begin
         rdata_next = mode_reg;
      end else if (bus_rd_i && bus_addr_i == KEY_ADDR) begin
         rdata_next = KEY_RESET;
      end else if (bus_rd_i) begin
         rdata_next = 8'h00;
      end
      rst_req_next = ovf && eff_rst && !stab_s2_reg;
      nmi_req_next = ovf && eff_nmi;
      osc_sw_next = ovf && eff_rst && stab_s2_reg;
   end

   // register stage with synchronous reset
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mode_reg <= MODE_RESET;
         written_reg <= 1'b0;
         cnt_reg <= '0;
         rdata_reg <= 8'h00;
         rst_req_reg <= 1'b0;
         nmi_req_reg <= 1'b0;
         osc_sw_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         written_reg <= written_next;
         cnt_reg <= cnt_next;
         rdata_reg <= rdata_next;
         rst_req_reg <= rst_req_next;
         nmi_req_reg <= nmi_req_next;
         osc_sw_reg <= osc_sw_next;
      end
   end

   // outputs straight from flops
   assign bus_rdata_o = rdata_reg;
   assign overflow_reset_request_o = rst_req_reg;
   assign overflow_nmi_request_o = nmi_req_reg;
   assign cpu_clk_to_osc_o = osc_sw_reg;

   //===========================================================
   // assertions
   //===========================================================
   sequence s_bad_key;
      key_wr && !key_good && eff_rst && !stab_s2_reg;
   endsequence

   sequence s_rst_pulse;
      overflow_reset_request_o && !overflow_nmi_request_o;
   endsequence

   a_reset_value: assert property (@(posedge ref_clk_i)
      $past(rst_i) && !rst_i |-> mode_reg == MODE_RESET && cnt_reg == '0)
      else $error("mode register reset value wrong");

   a_bad_key: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      s_bad_key |=> s_rst_pulse ##0 cnt_reg == '0)
      else $error("bad key did not force overflow");

   a_good_key: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      key_good && !mode_wr |=> cnt_reg == '0 && !overflow_reset_request_o)
      else $error("service key did not clear counter");

   a_mode_once: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      mode_wr && written_reg |=> $stable(mode_reg) && cnt_reg == '0
      && (overflow_reset_request_o || overflow_nmi_request_o || cpu_clk_to_osc_o || !eff_rst))
      else $error("second mode write mishandled");

   a_first_write: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      mode_wr && !written_reg |=> mode_reg == {1'b0, $past(bus_wdata_i[6:0])} && written_reg)
      else $error("first mode write not stored");

   a_mode_readback: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      bus_rd_i && bus_addr_i == MODE_ADDR |=> bus_rdata_o[7] == 1'b0)
      else $error("mode register bit 7 not zero");

   a_bit_op_key: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      key_wr && bus_bit_op_i && eff_rst && !stab_s2_reg |=> overflow_reset_request_o)
      else $error("bit access to key did not force overflow");

   a_stop_quiet: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !lock_s2_reg && mode_reg[6:5] == 2'b00 |=> !overflow_reset_request_o
      && !overflow_nmi_request_o)
      else $error("stopped watchdog raised a request");

   a_req_exclusive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !(overflow_reset_request_o && overflow_nmi_request_o))
      else $error("both requests asserted");

   a_lock_reset: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      lock_s2_reg && ovf && !stab_s2_reg |=> overflow_reset_request_o)
      else $error("locked watchdog did not request reset");

   a_stab_switch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ovf && eff_rst && stab_s2_reg |=> cpu_clk_to_osc_o && !overflow_reset_request_o)
      else $error("overflow in stabilisation not redirected");

   a_stop_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      !eff_run && !ovf && !key_good && !mode_wr |=> $stable(cnt_reg))
      else $error("stopped counter moved");

   a_key_read: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      bus_rd_i && bus_addr_i == KEY_ADDR |=> bus_rdata_o == KEY_RESET)
      else $error("service key read wrong");

   a_count_ovf: assert property (@(posedge ref_clk_i) disable iff (rst_i)
      ovf_count && eff_nmi |=> overflow_nmi_request_o ##1
      (!overflow_nmi_request_o || $past(ovf)))
      else $error("count overflow missed");

endmodule

// file: verilog/wdt_pkg.sv
//==============================================================
// watchdog constants
//==============================================================
package wdt_pkg;
   localparam logic [31:0] MODE_ADDR = 32'hFFFFF6D0;
   localparam logic [31:0] KEY_ADDR = 32'hFFFFF6D1;
   localparam logic [7:0] MODE_RESET = 8'h67;
   localparam logic [7:0] KEY_RESET = 8'h9A;
   localparam logic [7:0] KEY_SERVICE = 8'hAC;
   localparam logic [4:0] SEL_STOP = 5'h1F;
   localparam int MODE_HI_POS = 6;
   localparam int MODE_LO_POS = 5;
   localparam int SEL_MSB = 4;
   localparam int OSC_EXP_BASE = 12;
   localparam int MAIN_EXP_BASE = 16;
   localparam int CNT_W = 23;
endpackage

// file: sim/default_start_watchdog_tb_top.sv
`timescale 1ns/1ps
//==============================================================
// watchdog bench: bus driver, result monitor, scenarios
//==============================================================
module default_start_watchdog_tb_top;
   import wdt_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [31:0] bus_addr_i = '0;
   logic bus_wr_i = 1'b0;
   logic bus_rd_i = 1'b0;
   logic bus_bit_op_i = 1'b0;
   logic [7:0] bus_wdata_i = '0;
   logic osc_clk_i = 1'b0;
   logic lock_option_bit_i = 1'b0;
   logic osc_stab_i = 1'b0;
   logic [7:0] bus_rdata_o;
   logic rst_req, nmi_req, osc_sw;
   logic [2:0] pulses;
   logic rd_d = 1'b0;
   logic [7:0] rd_q[$];
   logic [2:0] pl_q[$];
   int fails = 0;
   int checks = 0;
   int cycles = 0;
   int seed = 32'h3820c46f;
   default_start_watchdog dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_addr_i(bus_addr_i),
      .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_bit_op_i(bus_bit_op_i),
      .bus_wdata_i(bus_wdata_i), .bus_rdata_o(bus_rdata_o), .osc_clk_i(osc_clk_i),
      .lock_option_bit_i(lock_option_bit_i), .osc_stab_i(osc_stab_i),
      .overflow_reset_request_o(rst_req), .overflow_nmi_request_o(nmi_req),
      .cpu_clk_to_osc_o(osc_sw));
   assign pulses = {osc_sw, nmi_req, rst_req};
   // clocks: main at 100 MHz, oscillator unrelated and slower
   always #5 ref_clk_i = ~ref_clk_i;
   always #37 osc_clk_i = ~osc_clk_i;
   task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic idle(int n);
      repeat (n) @(negedge ref_clk_i);
   endtask
   task automatic do_reset();
      rst_i = 1'b1;
      idle(6);
      rst_i = 1'b0;
   endtask
   task automatic wr(logic [31:0] a, logic [7:0] d, logic bitop);
      @(negedge ref_clk_i);
      bus_addr_i = a;
      bus_wdata_i = d;
      bus_bit_op_i = bitop;
      bus_wr_i = 1'b1;
      @(negedge ref_clk_i);
      bus_wr_i = 1'b0;
      bus_bit_op_i = 1'b0;
   endtask
   task automatic rd(logic [31:0] a, logic [7:0] exp);
      @(negedge ref_clk_i);
      bus_addr_i = a;
      bus_rd_i = 1'b1;
      rd_q.push_back(exp);
      @(negedge ref_clk_i);
      bus_rd_i = 1'b0;
   endtask
   // monitor: pops the oldest note whenever read data or a pulse shows
   always @(posedge ref_clk_i) begin
      rd_d <= bus_rd_i;
      if (rd_d) begin
         if (rd_q.size() == 0) cmp("read queue", 8'h01, 8'h00);
         else cmp("read data", rd_q.pop_front(), bus_rdata_o);
      end
      if (!rst_i && pulses !== 3'b000) begin
         if (pl_q.size() == 0) cmp("unexpected pulse", 8'h00, {5'h00, pulses});
         else cmp("overflow pulse", {5'h00, pl_q.pop_front()}, {5'h00, pulses});
      end
      cycles++;
      if (cycles == 90000) begin
         fails++;
         tally_and_finish();
      end
   end
   //==============================================================
   // scenarios
   //==============================================================
   initial begin
      logic [7:0] v;
      do_reset();
      rd(MODE_ADDR, MODE_RESET);
      rd(KEY_ADDR, KEY_RESET);
      rd(32'hFFFFF6D4, 8'h00);
      wr(MODE_ADDR, 8'h00, 1'b1);
      rd(MODE_ADDR, MODE_RESET);
      wr(32'hFFFFF6D4, 8'($random(seed)), 1'b0);
      wr(KEY_ADDR, KEY_SERVICE, 1'b0);
      rd(KEY_ADDR, KEY_RESET);
      for (int i = 0; i < 4; i++) begin
         v = 8'($random(seed));
         if (v == KEY_SERVICE) v = 8'h00;
         pl_q.push_back(3'b001);
         wr(KEY_ADDR, v, 1'($random(seed)));
         idle(2);
      end
      pl_q.push_back(3'b001);
      wr(KEY_ADDR, KEY_SERVICE, 1'b1);
      idle(2);
      $display("test defaults done");
      for (int m = 0; m < 4; m++) begin
         do_reset();
         v = {1'b0, 2'(m), 5'h08};
         wr(MODE_ADDR, v | 8'h80, 1'b0);
         rd(MODE_ADDR, v);
         if (m != 0) pl_q.push_back(m > 1 ? 3'b001 : 3'b010);
         wr(KEY_ADDR, 8'h55, 1'b0);
         idle(2);
      end
      $display("test modes done");
      do_reset();
      wr(MODE_ADDR, 8'h28, 1'b0);
      pl_q.push_back(3'b010);
      wr(MODE_ADDR, MODE_RESET, 1'b0);
      rd(MODE_ADDR, 8'h28);
      idle(65500);
      pl_q.push_back(3'b010);
      idle(40);
      $display("test interval done");
      lock_option_bit_i = 1'b1;
      do_reset();
      wr(MODE_ADDR, 8'h1F, 1'b0);
      pl_q.push_back(3'b001);
      wr(KEY_ADDR, 8'h55, 1'b0);
      idle(2);
      lock_option_bit_i = 1'b0;
      do_reset();
      osc_stab_i = 1'b1;
      idle(4);
      pl_q.push_back(3'b100);
      wr(KEY_ADDR, 8'h55, 1'b0);
      idle(4);
      osc_stab_i = 1'b0;
      cmp("pending pulses", 8'h00, 8'(pl_q.size()));
      $display("test lock and stabilisation done");
      tally_and_finish();
   end
endmodule
